// ---- bcc_bus_ctrl.sv ----
// Design decision made here: register access over APB.
`timescale 1ns/1ps
`default_nettype none
module bcc_bus_ctrl
(
   // Clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // Core request
   input  wire logic        req_valid,
   input  wire logic [1:0]  req_kind,
   input  wire logic [15:0] req_addr,
   input  wire logic [7:0]  req_wdata,
   output logic             req_ready,
   // Prefetch queue and branch cache feedback
   input  wire logic        pfq_stall,
   input  wire logic        fetch_abort,
   // Core response
   output logic             rsp_done,
   output logic             rsp_aborted,
   output logic             rsp_to_queue,
   output logic [15:0]      rsp_data,
   // Feature enables
   output logic             prefetch_queue_enable,
   output logic             branch_cache_enable,
   // Multiplexed memory bus
   input  wire logic [15:0] ad_in,
   output logic [15:0]      ad_out,
   output logic             ad_oe,
   output logic             ale,
   output logic             code_read_strobe_n,
   output logic             data_read_n,
   output logic             data_write_n
);

   ////////////////////////////////////////////////////////////////////////////
   // Types and state

   typedef enum logic [2:0]
   {
      ST_IDLE = 3'b001,
      ST_ADDR = 3'b010,
      ST_XFER = 3'b100
   } bcc_st_t;

   typedef struct packed
   {
      bcc_st_t            st;
      bcc_pkg::bcc_kind_t kind;
      logic [2:0]         len;
      logic [2:0]         cnt;
      logic [15:0]        addr;
      logic [7:0]         wdata;
      logic [15:0]        rdata;
      logic               done;
      logic               aborted;
      logic               to_queue;
      logic               stretched;
      logic               last_abort;
      logic               last_stretch;
      logic [15:0]        pin_ad;
      logic               pin_oe;
      logic               pin_ale;
      logic               pin_code_n;
      logic               pin_rd_n;
      logic               pin_wr_n;
   } bcc_core_t;

   bcc_core_t          q;
   bcc_core_t          d;
   bcc_pkg::bcc_kind_t kind_in;
   // Length cannot pass seven, so three bits suffice
   logic [2:0]         len_new;
   logic               is_code;
   logic               last_cnt;
   logic               accept;
   logic               abort_now;

   bcc_cfg_if cfg_if ();

   ////////////////////////////////////////////////////////////////////////////
   // Decode helpers

   // Fetches and constant reads share the code strobe and its stall rule
   function automatic logic is_code_f(input bcc_pkg::bcc_kind_t k);
      return (k == bcc_pkg::KIND_FETCH) || (k == bcc_pkg::KIND_CONST);
   endfunction

   // Only a fetch may be dropped; data and constant reads always finish
   function automatic logic may_abort_f(input bcc_pkg::bcc_kind_t k, input logic abort_req);
      return (k == bcc_pkg::KIND_FETCH) && abort_req;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Register file and length decode

   bcc_regs u_regs
   (
      .pclk    (pclk),
      .presetn (presetn),
      .psel    (psel),
      .penable (penable),
      .pwrite  (pwrite),
      .paddr   (paddr),
      .pwdata  (pwdata),
      .prdata  (prdata),
      .pready  (pready),
      .pslverr (pslverr),
      .cfg_bus (cfg_if.regs)
   );

   // Every two-bit code is a legal kind, so the cast cannot go astray
   assign kind_in = bcc_pkg::bcc_kind_t'(req_kind);

   // Length taken from the live register at start only
   bcc_len_dec u_len
   (
      .cfg  (cfg_if.cfg),
      .kind (kind_in),
      .len  (len_new)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Handshake and helpers

   assign req_ready = (q.st == ST_IDLE);
   assign accept    = req_valid & req_ready;
   assign is_code   = is_code_f(q.kind);
   assign abort_now = may_abort_f(q.kind, fetch_abort);
   // Count starts at the ale clock; last_cnt marks the final strobe clock
   assign last_cnt  = (q.cnt == 3'(q.len - 3'h1));

   ////////////////////////////////////////////////////////////////////////////
   // Sequencer: one address clock, then strobe clocks up to the length

   always_comb
   begin
      d      = q;
      d.done = 1'b0;
      unique case (q.st)
         ST_IDLE:
         begin
            if (accept)
            begin
               // Latch the whole request; the core may change its inputs meanwhile
               d.st        = ST_ADDR;
               d.kind      = kind_in;
               d.len       = len_new;
               d.cnt       = 3'h0;
               d.addr      = req_addr;
               d.wdata     = req_wdata;
               d.stretched = 1'b0;
            end
         end
         ST_ADDR:
         begin
            d.cnt = 3'(q.cnt + 3'h1);
            // Address clock over; strobe clocks follow
            d.st  = ST_XFER;
            // Only fetches may be dropped
            if (abort_now)
            begin
               d.st         = ST_IDLE;
               d.done       = 1'b1;
               d.aborted    = 1'b1;
               d.to_queue   = 1'b0;
               d.last_abort = 1'b1;
            end
         end
         ST_XFER:
         begin
            // Abort outranks the stall, so a dropped fetch never waits on the queue
            if (abort_now)
            begin
               d.st         = ST_IDLE;
               d.done       = 1'b1;
               d.aborted    = 1'b1;
               d.to_queue   = 1'b0;
               d.last_abort = 1'b1;
            end
            else if (last_cnt && is_code && pfq_stall)
            begin
               // Hold the strobe while the queue reloads
               d.stretched = 1'b1;
            end
            else if (last_cnt)
            begin
               // Data cycles ignore stalls, so equal counts match
               d.st           = ST_IDLE;
               d.done         = 1'b1;
               d.aborted      = 1'b0;
               d.last_abort   = 1'b0;
               d.last_stretch = q.stretched;
               // Fetch words go to the queue, constants to the core
               d.to_queue     = (q.kind == bcc_pkg::KIND_FETCH);
               // Code is a full word, data only the low byte
               if (is_code)
                  d.rdata = ad_in;
               else if (q.kind == bcc_pkg::KIND_DREAD)
                  d.rdata = {8'h00, ad_in[7:0]};
            end
            else
            begin
               d.cnt = 3'(q.cnt + 3'h1);
            end
         end
         default:
         begin
            d.st = ST_IDLE;
         end
      endcase

      // Pins follow the next state so they leave flip-flops cleanly
      d.pin_ale    = (d.st == ST_ADDR);
      d.pin_oe     = (d.st == ST_ADDR) | ((d.st == ST_XFER) && (d.kind == bcc_pkg::KIND_DWRITE));
      // Write data rides the low byte; the high byte keeps the address
      d.pin_ad     = (d.st == ST_ADDR) ? d.addr : {d.addr[15:8], d.wdata};
      d.pin_code_n = ~((d.st == ST_XFER) && is_code_f(d.kind));
      d.pin_rd_n   = ~((d.st == ST_XFER) && (d.kind == bcc_pkg::KIND_DREAD));
      d.pin_wr_n   = ~((d.st == ST_XFER) && (d.kind == bcc_pkg::KIND_DWRITE));
   end

   // State register; strobes idle high and bus released at reset
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         // Strobes are active low, so they rest high
         q              <= '0;
         q.st           <= ST_IDLE;
         q.kind         <= bcc_pkg::KIND_FETCH;
         q.pin_code_n   <= 1'b1;
         q.pin_rd_n     <= 1'b1;
         q.pin_wr_n     <= 1'b1;
      end
      else
      begin
         q <= d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs

   // Response data and flags hold until the next completion; rsp_done pulses for one clock
   assign rsp_done     = q.done;
   assign rsp_aborted  = q.aborted;
   assign rsp_to_queue = q.to_queue;
   assign rsp_data     = q.rdata;

   // Disabling a feature only informs the core; fetches are still served
   // Enables straight from the control register
   assign prefetch_queue_enable = cfg_if.cfg[bcc_pkg::PFQ_EN_BIT];
   assign branch_cache_enable   = cfg_if.cfg[bcc_pkg::BC_EN_BIT];

   assign ad_out             = q.pin_ad;
   assign ad_oe              = q.pin_oe;
   assign ale                = q.pin_ale;
   assign code_read_strobe_n = q.pin_code_n;
   assign data_read_n        = q.pin_rd_n;
   assign data_write_n       = q.pin_wr_n;

   // Status seen by software
   // Kind shows the cycle in flight while busy, else the last one
   always_comb
   begin
      cfg_if.status                                  = bcc_pkg::BUS_STAT_RST;
      cfg_if.status[bcc_pkg::STAT_BUSY_BIT]          = (q.st != ST_IDLE);
      cfg_if.status[bcc_pkg::STAT_KIND_LSB +: 2]     = q.kind;
      cfg_if.status[bcc_pkg::STAT_ABORT_BIT]         = q.last_abort;
      cfg_if.status[bcc_pkg::STAT_STRETCH_BIT]       = q.last_stretch;
   end

endmodule // bcc_bus_ctrl
`default_nettype wire

// ---- bcc_cfg_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface bcc_cfg_if;
   logic [7:0] cfg;
   logic [7:0] status;

   modport regs (output cfg, input status);
   modport core (input cfg, output status);
endinterface
`default_nettype wire

// ---- bcc_len_dec.sv ----
`timescale 1ns/1ps
`default_nettype none
module bcc_len_dec
(
   // Configuration and cycle kind
   input  wire logic [7:0]        cfg,
   input  wire bcc_pkg::bcc_kind_t kind,
   // Cycle length in clocks
   output logic [2:0]             len
);

   logic [1:0] code_w;
   logic [1:0] rd_w;
   logic [1:0] wr_w;

   // Field extraction
   assign code_w = cfg[bcc_pkg::CODE_WAIT_LSB +: 2];
   assign rd_w   = cfg[bcc_pkg::RD_WAIT_LSB +: 2];
   assign wr_w   = cfg[bcc_pkg::WR_WAIT_LSB +: 2];

   // One count per cycle type, whatever the address
   always_comb
   begin
      len = bcc_pkg::bcc_len_f(code_w, bcc_pkg::CODE_LEN_BASE);
      unique case (kind)
         bcc_pkg::KIND_FETCH:  len = bcc_pkg::bcc_len_f(code_w, bcc_pkg::CODE_LEN_BASE);
         bcc_pkg::KIND_CONST:
         begin
            // Shortest code setting is too fast for constant moves
            if (code_w == bcc_pkg::CODE_WAIT_MIN)
               len = bcc_pkg::CONST_MIN_LEN;
            else
               len = bcc_pkg::bcc_len_f(code_w, bcc_pkg::CODE_LEN_BASE);
         end
         bcc_pkg::KIND_DREAD:  len = bcc_pkg::bcc_len_f(rd_w, bcc_pkg::DATA_LEN_BASE);
         bcc_pkg::KIND_DWRITE: len = bcc_pkg::bcc_len_f(wr_w, bcc_pkg::DATA_LEN_BASE);
      endcase
   end

endmodule // bcc_len_dec
`default_nettype wire

// ---- bcc_mem_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module bcc_mem_model
(
   // Bus from the controller
   input  wire logic        pclk,
   input  wire logic [15:0] ad_out,
   input  wire logic        ale,
   input  wire logic        code_read_strobe_n,
   input  wire logic        data_read_n,
   input  wire logic        data_write_n,
   // Read data back
   output logic [15:0]      ad_in
);
   logic [15:0] addr_q;
   logic [15:0] last_q = 16'h0000;
   logic [7:0]  mem [256];

   // Known contents, so untouched bytes read predictably
   initial
      for (int i = 0; i < 256; i++)
         mem[i] = 8'(i) ^ 8'h3c;

   // Latch address, store written bytes, remember last bus value
   always @(posedge pclk)
   begin
      if (ale)
         addr_q <= ad_out;
      if (!data_write_n)
         mem[addr_q[7:0]] <= ad_out[7:0];
      last_q <= ad_in;
   end

   ////////////////////////////////////////
   // Released bus toggles, so a stale value never passes for data
   always_comb
      if (!code_read_strobe_n)
         ad_in = addr_q ^ 16'h5a3c;
      else if (!data_read_n)
         ad_in = {~addr_q[15:8], mem[addr_q[7:0]]};
      else
         ad_in = ~last_q;
endmodule // bcc_mem_model
`default_nettype wire

// ---- bcc_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
module bcc_monitor
(
   // Clock, reset, register bus
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   // Core side
   input wire logic        req_valid,
   input wire logic [1:0]  req_kind,
   input wire logic        req_ready,
   input wire logic        pfq_stall,
   input wire logic        fetch_abort,
   input wire logic        rsp_done,
   input wire logic        rsp_aborted,
   input wire logic [15:0] rsp_data,
   // Pins and enables
   input wire logic        prefetch_queue_enable,
   input wire logic        branch_cache_enable,
   input wire logic [15:0] ad_in,
   input wire logic        code_read_strobe_n,
   input wire logic        ad_oe,
   input wire logic        ale,
   input wire logic        data_write_n
);
   logic [7:0] cfg_q, cyc_q, stall_q, ad_lo;
   logic [3:0] len_q, len_d;
   logic [1:0] kind_q, code, en_w;
   logic       busy_q, wr_ctrl;

   // Control value as written, and the length it implies for a new request
   assign wr_ctrl = psel && penable && pwrite && paddr[11:2] == 10'h09d;
   assign en_w    = pwdata[7:6];
   assign ad_lo   = ad_in[7:0];
   assign code    = req_kind == 2'h3 ? cfg_q[5:4] : (req_kind == 2'h2 ? cfg_q[3:2] : cfg_q[1:0]);
   assign len_d   = (req_kind[1] ? 4'h4 : 4'h3) + {2'h0, code} + {3'h0, req_kind == 2'h1 && code == 2'h0};

   // Cycles since acceptance; stalled clocks counted apart
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         cfg_q  <= 8'heb;
         busy_q <= 1'b0;
      end
      else
      begin
         if (wr_ctrl)
            cfg_q <= pwdata[7:0];
         if (req_valid && req_ready)
         begin
            busy_q  <= 1'b1;
            kind_q  <= req_kind;
            len_q   <= len_d;
            cyc_q   <= 8'h01;
            stall_q <= 8'h00;
         end
         else if (rsp_done)
            busy_q <= 1'b0;
         else if (busy_q)
         begin
            cyc_q   <= cyc_q + 8'h01;
            stall_q <= stall_q + {7'h00, pfq_stall && !code_read_strobe_n && cyc_q >= {4'h0, len_q}};
         end
      end

   ////////////////////////////////////////
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   sequence s_code_done;
      rsp_done && busy_q && !kind_q[1] && !rsp_aborted;
   endsequence
   sequence s_data_done;
      rsp_done && busy_q && kind_q[1];
   endsequence

   a_reset_enables: assert property (!$past(presetn) |-> prefetch_queue_enable && branch_cache_enable)
      else $error("enables low after reset");
   a_enable_write: assert property (wr_ctrl |=> {prefetch_queue_enable, branch_cache_enable} == $past(en_w))
      else $error("enables do not follow write");
   a_data_length: assert property (s_data_done |-> cyc_q == {4'h0, len_q} + 8'h01)
      else $error("data cycle length wrong");
   a_code_length: assert property (s_code_done |-> cyc_q == {4'h0, len_q} + 8'h01 + stall_q)
      else $error("code cycle length wrong");
   a_abort_fetch: assert property (busy_q && kind_q == 2'h0 && fetch_abort && !code_read_strobe_n |=> rsp_done && rsp_aborted)
      else $error("fetch not cut short");
   a_data_no_abort: assert property (s_data_done |-> !rsp_aborted)
      else $error("data cycle aborted");
   a_code_word: assert property (s_code_done |-> rsp_data == $past(ad_in))
      else $error("code word not taken whole");
   a_byte_read: assert property (s_data_done and kind_q == 2'h2 |-> rsp_data == {8'h00, $past(ad_lo)})
      else $error("data read not a byte");
   a_pin_drive: assert property (ad_oe == (ale || !data_write_n))
      else $error("bus drive outside address or write clocks");
endmodule // bcc_monitor
`default_nettype wire

// ---- bcc_pkg.sv ----
`default_nettype none
package bcc_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Register map: printed offsets are indexes, byte address is four times that
   localparam logic [9:0] BUS_CTRL_IDX  = 10'h09d;
   localparam logic [9:0] BUS_STAT_IDX  = 10'h09e;
   localparam logic [7:0] BUS_CTRL_RST  = 8'heb;
   localparam logic [7:0] BUS_STAT_RST  = 8'h00;

   ////////////////////////////////////////////////////////////////////////////
   // Control field positions
   localparam int unsigned PFQ_EN_BIT   = 7;
   localparam int unsigned BC_EN_BIT    = 6;
   localparam int unsigned WR_WAIT_LSB  = 4;
   localparam int unsigned RD_WAIT_LSB  = 2;
   localparam int unsigned CODE_WAIT_LSB = 0;

   ////////////////////////////////////////////////////////////////////////////
   // Status field positions
   localparam int unsigned STAT_BUSY_BIT    = 0;
   localparam int unsigned STAT_KIND_LSB    = 1;
   localparam int unsigned STAT_ABORT_BIT   = 3;
   localparam int unsigned STAT_STRETCH_BIT = 4;

   ////////////////////////////////////////////////////////////////////////////
   // Cycle lengths in core clock periods
   localparam logic [2:0] DATA_LEN_BASE  = 3'h4;
   localparam logic [2:0] CODE_LEN_BASE  = 3'h3;
   localparam logic [2:0] CONST_MIN_LEN  = 3'h4;
   localparam logic [1:0] CODE_WAIT_MIN  = 2'h0;

   ////////////////////////////////////////////////////////////////////////////
   // Bus cycle kinds
   typedef enum logic [1:0]
   {
      KIND_FETCH  = 2'h0,
      KIND_CONST  = 2'h1,
      KIND_DREAD  = 2'h2,
      KIND_DWRITE = 2'h3
   } bcc_kind_t;

   // Wait code to clock count; base plus code never exceeds seven
   function automatic logic [2:0] bcc_len_f(input logic [1:0] code, input logic [2:0] base);
      return 3'(base + {1'b0, code});
   endfunction

endpackage
`default_nettype wire

// ---- bcc_regs.sv ----
`timescale 1ns/1ps
`default_nettype none
module bcc_regs
(
   // Clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // Configuration to the sequencer
   bcc_cfg_if.regs          cfg_bus
);

   typedef struct packed
   {
      logic [7:0] ctrl;
   } bcc_reg_state_t;

   bcc_reg_state_t q;
   bcc_reg_state_t d;
   logic           sel_ctrl;
   logic           sel_stat;
   logic           access;

   ////////////////////////////////////////////////////////////////////////////
   // Decode
   assign sel_ctrl = (paddr[11:2] == bcc_pkg::BUS_CTRL_IDX);
   assign sel_stat = (paddr[11:2] == bcc_pkg::BUS_STAT_IDX);
   assign access   = psel & penable;

   // Zero wait states; status is read only
   assign pready  = 1'b1;
   assign pslverr = access & ~(sel_ctrl | (sel_stat & ~pwrite));

   // Unmapped reads return zero
   always_comb
   begin
      prdata = 32'h0000_0000;
      if (sel_ctrl)
         prdata = {24'h00_0000, q.ctrl};
      else if (sel_stat)
         prdata = {24'h00_0000, cfg_bus.status};
   end

   ////////////////////////////////////////////////////////////////////////////
   // Control register, writable at run time
   always_comb
   begin
      d = q;
      if (access & pwrite & sel_ctrl)
         d.ctrl = pwdata[7:0];
   end

   // Reset loads slow cycles with both features on
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         q.ctrl <= bcc_pkg::BUS_CTRL_RST;
      else
         q <= d;
   end

   assign cfg_bus.cfg = q.ctrl;

endmodule // bcc_regs
`default_nettype wire

// ---- tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   typedef struct {int done_at; logic [15:0] data; logic abrt; logic toq;} bcc_exp_t;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, ad_oe, ale;
   logic        req_valid, req_ready, pfq_stall, fetch_abort, rsp_done, rsp_aborted, rsp_to_queue;
   logic        prefetch_queue_enable, branch_cache_enable, code_read_strobe_n, data_read_n, data_write_n;
   logic [1:0]  req_kind;
   logic [7:0]  req_wdata, cfg_s;
   logic [7:0]  shadow [256];
   logic [11:0] paddr;
   logic [15:0] req_addr, rsp_data, ad_in, ad_out, last_data, a;
   logic [31:0] pwdata, prdata, rdv;
   bcc_exp_t    exp_q [$];
   int          failures = 0, check_count = 0, cyc_now = 0;

   bcc_bus_ctrl u_bcc_bus_ctrl (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .req_valid, .req_kind, .req_addr, .req_wdata, .req_ready, .pfq_stall, .fetch_abort, .rsp_done,
      .rsp_aborted, .rsp_to_queue, .rsp_data, .prefetch_queue_enable, .branch_cache_enable, .ad_in, .ad_out,
      .ad_oe, .ale, .code_read_strobe_n, .data_read_n, .data_write_n);
   bcc_mem_model u_bcc_mem_model (.pclk, .ad_out, .ale, .code_read_strobe_n, .data_read_n, .data_write_n, .ad_in);

   // Core clock and a cycle count for completion times
   always #10 pclk = ~pclk;
   always @(posedge pclk) cyc_now <= cyc_now + 1;

   ////////////////////////////////////////
   task automatic bad(input string msg);
      failures++;
      $display("BAD %0t %s", $time, msg);
   endtask
   task automatic test_done();
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic chk_reg(input logic [31:0] got, input logic [31:0] want);
      check_count++;
      if (got !== want) bad($sformatf("register %h want %h", got, want));
   endtask
   task automatic chk_rsp(input bcc_exp_t e);
      check_count++;
      if (cyc_now != e.done_at || rsp_data !== e.data || rsp_aborted !== e.abrt || rsp_to_queue !== e.toq)
         bad($sformatf("done at %0d data %h, want %0d %h", cyc_now, rsp_data, e.done_at, e.data));
   endtask
   function automatic int len_of(input logic [1:0] k);
      logic [1:0] c;
      c = k == 2'h3 ? cfg_s[5:4] : (k == 2'h2 ? cfg_s[3:2] : cfg_s[1:0]);
      return (k[1] ? 4 : 3) + c + ((k == 2'h1 && c == 2'h0) ? 1 : 0);
   endfunction

   // Register bus transfer; the request holds until pready is seen
   task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] wd, input logic err_want);
      int   n;
      logic rdy, err;
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= ad;
      pwdata  <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge pclk);
         rdy = pready;
         rdv = prdata;
         err = pslverr;
         n++;
      end
      while (rdy !== 1'b1 && n < 20);
      if (n >= 20) begin bad("bus hang"); test_done(); end
      chk_reg({31'h0, err}, {31'h0, err_want});
      if (wr && !err_want && ad == 12'h274) cfg_s = wd[7:0];
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   // Core request: waits for acceptance, then notes the expected completion
   task automatic core_req(input logic [1:0] k, input logic [15:0] ad, input int extra, input logic abt);
      bcc_exp_t   e;
      logic [7:0] wd;
      logic       rdy;
      int         n;
      wd = 8'($urandom);
      req_valid <= 1'b1;
      req_kind  <= k;
      req_addr  <= ad;
      req_wdata <= wd;
      n = 0;
      do
      begin
         @(posedge pclk);
         rdy = req_ready;
         e.done_at = abt ? cyc_now + 3 : cyc_now + len_of(k) + 1 + extra;
         n++;
      end
      while (rdy !== 1'b1 && n < 20);
      if (n >= 20) begin bad("core hang"); test_done(); end
      e.abrt = abt;
      e.toq  = k == 2'h0 && !abt;
      e.data = (abt || k == 2'h3) ? last_data : (k == 2'h2 ? {8'h00, shadow[ad[7:0]]} : ad ^ 16'h5a3c);
      if (k == 2'h3) shadow[ad[7:0]] = wd;
      last_data = e.data;
      exp_q.push_back(e);
   endtask
   task automatic drain();
      int n;
      req_valid <= 1'b0;
      for (n = 0; exp_q.size() != 0 && n < 40; n++)
         @(posedge pclk);
      if (n >= 40) begin bad("completion missing"); test_done(); end
      @(posedge pclk);
   endtask

   // Each completion is matched against the oldest note
   always @(negedge pclk)
      if (presetn === 1'b1 && rsp_done === 1'b1)
         if (exp_q.size() == 0) bad("completion without request");
         else chk_rsp(exp_q.pop_front());

   ////////////////////////////////////////
   initial
   begin
      logic [7:0] cfgs [6];
      cfgs = '{8'hc1, 8'hc0, 8'h00, 8'h55, 8'haa, 8'hff};
      pclk = 1'b0;
      presetn = 1'b0;
      {psel, penable, pwrite, paddr, pwdata, req_valid, req_kind, req_addr, req_wdata, pfq_stall, fetch_abort} = '0;
      cfg_s = 8'heb;
      last_data = 16'h0000;
      for (int i = 0; i < 256; i++)
         shadow[i] = 8'(i) ^ 8'h3c;
      void'($urandom(32'hcd10));
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      // Defaults, then refused accesses
      apb(1'b0, 12'h274, 32'h0, 1'b0);
      chk_reg(rdv, 32'h0000_00eb);
      apb(1'b0, 12'h280, 32'h0, 1'b1);
      chk_reg(rdv, 32'h0);
      apb(1'b1, 12'h278, 32'h0000_00ff, 1'b1);
      // Every wait code in every field, recommended settings first, back to back
      foreach (cfgs[i])
      begin
         apb(1'b1, 12'h274, {24'h0, 2'($urandom), cfgs[i][5:0]}, 1'b0);
         apb(1'b0, 12'h274, 32'h0, 1'b0);
         chk_reg(rdv, {24'h0, cfg_s});
         a = 16'($urandom);
         core_req(2'h0, a, 0, 1'b0);
         core_req(2'h1, a + 16'h0002, 0, 1'b0);
         core_req(2'h3, a, 0, 1'b0);
         core_req(2'h2, a, 0, 1'b0);
         core_req(2'h2, a ^ 16'h0100, 0, 1'b0);
         drain();
      end
      // Reload stall stretches a code read only; abort cuts a fetch only
      for (int k = 0; k < 3; k += 2)
      begin
         core_req(2'(k), a, k == 0 ? 2 : 0, 1'b0);
         req_valid <= 1'b0;
         pfq_stall <= 1'b1;
         repeat (len_of(2'(k)) + 1) @(posedge pclk);
         pfq_stall <= 1'b0;
         drain();
         apb(1'b0, 12'h278, 32'h0, 1'b0);
         chk_reg(rdv, k == 0 ? 32'h0000_0010 : 32'h0000_0004);
         core_req(2'(k), a, 0, k == 0);
         req_valid <= 1'b0;
         @(posedge pclk);
         fetch_abort <= 1'b1;
         @(posedge pclk);
         fetch_abort <= 1'b0;
         drain();
      end
      // A new setting leaves the cycle in flight alone
      apb(1'b1, 12'h274, 32'h0000_00c0, 1'b0);
      core_req(2'h2, a, 0, 1'b0);
      req_valid <= 1'b0;
      apb(1'b1, 12'h274, 32'h0000_00cc, 1'b0);
      core_req(2'h2, a, 0, 1'b0);
      drain();
      // Second reset brings the defaults back
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      cfg_s = 8'heb;
      last_data = 16'h0000;
      @(posedge pclk);
      apb(1'b0, 12'h274, 32'h0, 1'b0);
      chk_reg(rdv, 32'h0000_00eb);
      test_done();
   end
endmodule // tb_top

bind bcc_bus_ctrl bcc_monitor u_bcc_monitor (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .req_valid,
   .req_kind, .req_ready, .pfq_stall, .fetch_abort, .rsp_done, .rsp_aborted, .rsp_data, .prefetch_queue_enable,
   .branch_cache_enable, .ad_in, .code_read_strobe_n, .ad_oe, .ale, .data_write_n);
`default_nettype wire
